// ---- hdl/daz_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the range/zero control
`ifndef DAZ_CFG_SVH
`define DAZ_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DAZ_ADR_CTRL 8'h00
`define DAZ_ADR_CMD 8'h04
`define DAZ_ADR_RANGE 8'h08
`define DAZ_ADR_ARMODE 8'h0C
`define DAZ_ADR_APER 8'h10
`define DAZ_ADR_COUNT 8'h14
`define DAZ_ADR_STATUS 8'h18
`define DAZ_ADR_FIDX 8'h1C
`define DAZ_ADR_FDATA 8'h20

// ****************************************
// Field positions
// ****************************************
`define DAZ_CTRL_FUNC_LSB 0
`define DAZ_CTRL_AZ_BIT 4
`define DAZ_CMD_INIT_BIT 0
`define DAZ_CMD_CONF_BIT 1
`define DAZ_CMD_MEAS_BIT 2
`define DAZ_CMD_AZ_BIT 3
`define DAZ_STAT_BUSY_BIT 0
`define DAZ_STAT_DONE_BIT 1
`define DAZ_STAT_ABORT_BIT 2
`define DAZ_STAT_NVRDY_BIT 3
`define DAZ_STAT_CNT_LSB 8
`define DAZ_STAT_RNG_LSB 16
`define DAZ_RANGE_RES_LSB 8

// ****************************************
// Reset values
// ****************************************
`define DAZ_RST_FUNC 3'h0
`define DAZ_RST_AZ 1'h0
`define DAZ_RST_RANGE 3'h0
`define DAZ_RST_COUNT 16'h0001

// ****************************************
// Timing and scaling
// ****************************************
`define DAZ_APERTURE_MS 200
`define DAZ_CLK_MHZ 100
`define DAZ_RANGE_BASE_MV 32'h0000001E
`define DAZ_RANGE_STEP 32'h0000000A
`define DAZ_FS_COUNTS 32'h000493E0
`define DAZ_LO_PERMIL 32'h00000064
`define DAZ_HYST_PERMIL 32'h00000005
`define DAZ_PERMIL 32'h000003E8
`define DAZ_RES_EXP0 8'hF9
`define DAZ_OVR_POS 32'h7FFFFFFF
`define DAZ_OVR_NEG 32'h80000001

`endif

// ---- hdl/daz_pkg.sv ----
// Types shared by the range/zero control and its converter port
package daz_pkg;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {
    DAZ_AR_OFF = 2'h0,
    DAZ_AR_ON = 2'h1,
    DAZ_AR_ONCE = 2'h2
  } daz_ar_mode_t;

  typedef enum logic [3:0] {
    DAZ_ST_NVLOAD = 4'h0,
    DAZ_ST_NVWAIT = 4'h1,
    DAZ_ST_IDLE = 4'h2,
    DAZ_ST_SRCH_REQ = 4'h3,
    DAZ_ST_SRCH_WAIT = 4'h4,
    DAZ_ST_ZERO_REQ = 4'h5,
    DAZ_ST_ZERO_WAIT = 4'h6,
    DAZ_ST_MEAS_REQ = 4'h7,
    DAZ_ST_MEAS_WAIT = 4'h8
  } daz_state_t;

  // ****************************************
  // Converter carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic abort;
    logic zero;
    logic [2:0] func;
    logic [2:0] range;
    logic [31:0] aperture;
  } daz_conv_req_t;

  typedef struct packed {
    logic done;
    logic [31:0] data;
  } daz_conv_res_t;

endpackage : daz_pkg

// ---- hdl/daz_ctrl.sv ----
// Autorange and autozero sequencing of the converter front end, with Wishbone registers
//
// Implementation choices: the register offsets and the Wishbone register port.
`include "daz_cfg.svh"

// Function
// - Autorange ONCE searches range once per start, before the first measurement.
// - Autorange ONCE keeps the found range for the rest of the acquisition.
// - Autorange ONCE stores a signed overrange marker for readings beyond range.
// - Autorange ON checks each reading, switches range and retakes when out of band.
// - Autorange ON lowers the ten percent threshold by half a percent after upranging.
// - Autorange OFF never changes range; measures on programmed range only.
// - Each function holds its own autorange mode.
// - After reset, calibration offsets load from nonvolatile memory and correct readings.
// - Autozero ONCE zeroes active function and range now; later readings use it.
// - Autozero ONCE during sampling aborts the acquisition.
// - Autozero ON zeroes before first reading and after range change; OFF never.
// - Range search finishes before the autozero on the found range.
// - One autozero mode covers all functions and ranges.
// - Autozero offsets live only in volatile storage, never written back.
// - A programmed range value selects the nearest range at or above it.
// - Reported resolution follows the range, keeping six significant digits.
// - Configure without range or resolution sets autorange and 200 ms aperture.
// - Initiate acquires with the active configuration; status shows completion.
// - Measure command configures then initiates; fetch is a buffer read.
module daz_ctrl #(
  parameter int NFUNC = 6,
  parameter int NRANGE = 5,
  parameter int BUF_DEPTH = 16,
  parameter int OW = $clog2(NFUNC * NRANGE),
  parameter logic [31:0] DEF_APERTURE_CYC = 32'(`DAZ_APERTURE_MS * 1000 * `DAZ_CLK_MHZ)
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output daz_pkg::daz_conv_req_t conv_o,
  input wire daz_pkg::daz_conv_res_t conv_res_i,
  output logic nv_req_o,
  output logic [OW-1:0] nv_addr_o,
  input wire logic [31:0] nv_data_i,
  input wire logic nv_valid_i
);

  // ****************************************
  // Constants and helpers
  // ****************************************
  localparam int NOFS = NFUNC * NRANGE;
  localparam int BW = $clog2(BUF_DEPTH);
  localparam logic [31:0] FS = `DAZ_FS_COUNTS;
  localparam logic [31:0] LO_TH = FS * `DAZ_LO_PERMIL / `DAZ_PERMIL;
  localparam logic [31:0] HYST_TH = FS * (`DAZ_LO_PERMIL - `DAZ_HYST_PERMIL) / `DAZ_PERMIL;
  localparam logic [2:0] TOP_RANGE = 3'(NRANGE - 1);
  localparam logic [OW-1:0] LAST_OFS = OW'(NOFS - 1);

  function automatic logic [OW-1:0] ofs_idx(input logic [2:0] f, input logic [2:0] r);
    logic [7:0] t;
    t = 8'(f) * 8'(NRANGE) + 8'(r);
    return t[OW-1:0];
  endfunction : ofs_idx

  function automatic logic [2:0] nearest_range(input logic [31:0] req);
    logic [2:0] r;
    logic [31:0] fs;
    logic hit;
    r = TOP_RANGE;
    fs = `DAZ_RANGE_BASE_MV;
    hit = 1'b0;
    for (int i = 0; i < NRANGE; i++) begin
      if (!hit && fs >= req) begin
        r = 3'(i);
        hit = 1'b1;
      end
      fs = 32'(fs * `DAZ_RANGE_STEP);
    end
    return r;
  endfunction : nearest_range

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // ****************************************
  // State
  // ****************************************
  daz_pkg::daz_state_t state;
  logic [2:0] func_sel;
  logic az_mode;
  logic [2:0] range_q [NFUNC];
  daz_pkg::daz_ar_mode_t ar_mode [NFUNC];
  logic [31:0] aper [NFUNC];
  logic [15:0] count_q [NFUNC];
  logic [31:0] cal_ofs [NOFS];
  logic [31:0] az_ofs [NOFS];
  logic [NOFS-1:0] az_vld;
  logic [31:0] buf_mem [BUF_DEPTH];
  logic [BW:0] buf_cnt;
  logic [BW-1:0] fetch_idx;
  logic [2:0] act_func;
  logic [2:0] act_range;
  logic [15:0] meas_left;
  logic [OW-1:0] ld_idx;
  logic hyst;
  logic zero_only;
  logic done_f;
  logic abort_f;
  logic nv_ready;

  // ****************************************
  // Bus decode
  // ****************************************
  logic wb_req;
  logic wb_wr;
  logic lane0_wr;
  logic cmd_init;
  logic cmd_conf;
  logic cmd_meas;
  logic cmd_az;
  logic cmd_start;
  logic busy;
  logic abort_now;
  logic [31:0] rd_mux;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign lane0_wr = wb_wr & wb_sel_i[0];
  assign cmd_init = lane0_wr && wb_adr_i == `DAZ_ADR_CMD && wb_dat_i[`DAZ_CMD_INIT_BIT];
  assign cmd_conf = lane0_wr && wb_adr_i == `DAZ_ADR_CMD && wb_dat_i[`DAZ_CMD_CONF_BIT];
  assign cmd_meas = lane0_wr && wb_adr_i == `DAZ_ADR_CMD && wb_dat_i[`DAZ_CMD_MEAS_BIT];
  assign cmd_az = lane0_wr && wb_adr_i == `DAZ_ADR_CMD && wb_dat_i[`DAZ_CMD_AZ_BIT];
  assign cmd_start = cmd_init | cmd_meas;
  assign busy = state != daz_pkg::DAZ_ST_IDLE;
  assign abort_now = cmd_az && busy && nv_ready;

  always_comb begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `DAZ_ADR_CTRL: begin
        rd_mux[`DAZ_CTRL_FUNC_LSB +: 3] = func_sel;
        rd_mux[`DAZ_CTRL_AZ_BIT] = az_mode;
      end
      `DAZ_ADR_RANGE: begin
        rd_mux[2:0] = range_q[func_sel];
        rd_mux[`DAZ_RANGE_RES_LSB +: 8] = 8'(`DAZ_RES_EXP0 + 8'(range_q[func_sel]));
      end
      `DAZ_ADR_ARMODE: rd_mux[1:0] = ar_mode[func_sel];
      `DAZ_ADR_APER: rd_mux = aper[func_sel];
      `DAZ_ADR_COUNT: rd_mux[15:0] = count_q[func_sel];
      `DAZ_ADR_STATUS: begin
        rd_mux[`DAZ_STAT_BUSY_BIT] = busy;
        rd_mux[`DAZ_STAT_DONE_BIT] = done_f;
        rd_mux[`DAZ_STAT_ABORT_BIT] = abort_f;
        rd_mux[`DAZ_STAT_NVRDY_BIT] = nv_ready;
        rd_mux[`DAZ_STAT_CNT_LSB +: BW+1] = buf_cnt;
        rd_mux[`DAZ_STAT_RNG_LSB +: 3] = act_range;
      end
      `DAZ_ADR_FIDX: rd_mux[BW-1:0] = fetch_idx;
      `DAZ_ADR_FDATA: rd_mux = buf_mem[fetch_idx];
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      func_sel <= `DAZ_RST_FUNC;
      az_mode <= `DAZ_RST_AZ;
      fetch_idx <= '0;
    end else if (ce_i) begin
      if (lane0_wr && wb_adr_i == `DAZ_ADR_CTRL) begin
        func_sel <= wb_dat_i[`DAZ_CTRL_FUNC_LSB +: 3];
        az_mode <= wb_dat_i[`DAZ_CTRL_AZ_BIT];
      end
      if (lane0_wr && wb_adr_i == `DAZ_ADR_FIDX) begin
        fetch_idx <= wb_dat_i[BW-1:0];
      end
    end
  end

  // Per-function table; a configure command without arguments restores autorange defaults
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int f = 0; f < NFUNC; f++) begin
        ar_mode[f] <= daz_pkg::DAZ_AR_ON;
        aper[f] <= DEF_APERTURE_CYC;
        count_q[f] <= `DAZ_RST_COUNT;
      end
    end else if (ce_i) begin
      if (cmd_conf || cmd_meas) begin
        ar_mode[func_sel] <= daz_pkg::DAZ_AR_ON;
        aper[func_sel] <= DEF_APERTURE_CYC;
      end else begin
        if (lane0_wr && wb_adr_i == `DAZ_ADR_ARMODE) begin
          ar_mode[func_sel] <= daz_pkg::daz_ar_mode_t'(wb_dat_i[1:0]);
        end
        if (wb_wr && wb_adr_i == `DAZ_ADR_APER) begin
          aper[func_sel] <= merge(aper[func_sel], wb_dat_i, wb_sel_i);
        end
        if (wb_wr && wb_adr_i == `DAZ_ADR_COUNT && wb_sel_i[1:0] == 2'h3) begin
          count_q[func_sel] <= wb_dat_i[15:0];
        end
      end
    end
  end

  // ****************************************
  // Reading evaluation
  // ****************************************
  logic [OW-1:0] cur_idx;
  logic [31:0] cur_ofs;
  logic [31:0] corr;
  logic [31:0] mag;
  logic over;
  logic under;
  logic srch_done;
  logic meas_done;
  logic zero_done;
  logic rng_up;
  logic rng_dn;
  logic store_en;
  logic [31:0] store_val;

  always_comb begin
    cur_idx = ofs_idx(act_func, act_range);
    cur_ofs = az_vld[cur_idx] ? az_ofs[cur_idx] : cal_ofs[cur_idx];
    corr = conv_res_i.data - cur_ofs;
    mag = corr[31] ? 32'(-corr) : corr;
    over = mag > FS;
    under = mag < (hyst ? HYST_TH : LO_TH);
    srch_done = state == daz_pkg::DAZ_ST_SRCH_WAIT && conv_res_i.done && !cmd_az;
    meas_done = state == daz_pkg::DAZ_ST_MEAS_WAIT && conv_res_i.done && !cmd_az;
    zero_done = state == daz_pkg::DAZ_ST_ZERO_WAIT && conv_res_i.done && !cmd_az;
    // Only ON mode moves the range after the search; ONCE and OFF stay put
    rng_up = (srch_done || (meas_done && ar_mode[act_func] == daz_pkg::DAZ_AR_ON))
             && over && act_range < TOP_RANGE;
    rng_dn = (srch_done || (meas_done && ar_mode[act_func] == daz_pkg::DAZ_AR_ON))
             && under && !over && act_range != 3'h0;
    store_en = meas_done && !rng_up && !rng_dn;
    store_val = over ? (corr[31] ? `DAZ_OVR_NEG : `DAZ_OVR_POS) : corr;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= daz_pkg::DAZ_ST_NVLOAD;
      ld_idx <= '0;
      nv_req_o <= 1'b0;
      nv_addr_o <= '0;
      nv_ready <= 1'b0;
      act_func <= 3'h0;
      act_range <= 3'h0;
      meas_left <= 16'h0000;
      buf_cnt <= '0;
      hyst <= 1'b0;
      zero_only <= 1'b0;
      done_f <= 1'b0;
      abort_f <= 1'b0;
    end else if (ce_i) begin
      nv_req_o <= 1'b0;
      if (rng_up) begin
        act_range <= act_range + 3'h1;
        hyst <= 1'b1;
      end else if (rng_dn) begin
        act_range <= act_range - 3'h1;
        hyst <= 1'b0;
      end
      if (store_en && buf_cnt < (BW+1)'(BUF_DEPTH)) begin
        buf_cnt <= buf_cnt + (BW+1)'(1);
      end
      if (abort_now) begin
        abort_f <= 1'b1;
        zero_only <= 1'b1;
        state <= daz_pkg::DAZ_ST_ZERO_REQ;
      end else begin
        case (state)
          daz_pkg::DAZ_ST_NVLOAD: begin
            nv_req_o <= 1'b1;
            nv_addr_o <= ld_idx;
            state <= daz_pkg::DAZ_ST_NVWAIT;
          end
          daz_pkg::DAZ_ST_NVWAIT: begin
            if (nv_valid_i) begin
              if (ld_idx == LAST_OFS) begin
                nv_ready <= 1'b1;
                state <= daz_pkg::DAZ_ST_IDLE;
              end else begin
                ld_idx <= ld_idx + OW'(1);
                state <= daz_pkg::DAZ_ST_NVLOAD;
              end
            end
          end
          daz_pkg::DAZ_ST_IDLE: begin
            act_func <= func_sel;
            act_range <= range_q[func_sel];
            if (cmd_az) begin
              zero_only <= 1'b1;
              state <= daz_pkg::DAZ_ST_ZERO_REQ;
            end else if (cmd_start) begin
              zero_only <= 1'b0;
              done_f <= 1'b0;
              abort_f <= 1'b0;
              buf_cnt <= '0;
              meas_left <= count_q[func_sel] == 16'h0000 ? 16'h0001 : count_q[func_sel];
              if (cmd_meas || ar_mode[func_sel] != daz_pkg::DAZ_AR_OFF) begin
                state <= daz_pkg::DAZ_ST_SRCH_REQ;
              end else if (az_mode) begin
                state <= daz_pkg::DAZ_ST_ZERO_REQ;
              end else begin
                state <= daz_pkg::DAZ_ST_MEAS_REQ;
              end
            end
          end
          daz_pkg::DAZ_ST_SRCH_REQ: state <= daz_pkg::DAZ_ST_SRCH_WAIT;
          daz_pkg::DAZ_ST_SRCH_WAIT: begin
            if (srch_done) begin
              if (rng_up || rng_dn) begin
                state <= daz_pkg::DAZ_ST_SRCH_REQ;
              end else if (az_mode) begin
                state <= daz_pkg::DAZ_ST_ZERO_REQ;
              end else begin
                state <= daz_pkg::DAZ_ST_MEAS_REQ;
              end
            end
          end
          daz_pkg::DAZ_ST_ZERO_REQ: state <= daz_pkg::DAZ_ST_ZERO_WAIT;
          daz_pkg::DAZ_ST_ZERO_WAIT: begin
            if (zero_done) begin
              state <= zero_only ? daz_pkg::DAZ_ST_IDLE : daz_pkg::DAZ_ST_MEAS_REQ;
            end
          end
          daz_pkg::DAZ_ST_MEAS_REQ: state <= daz_pkg::DAZ_ST_MEAS_WAIT;
          daz_pkg::DAZ_ST_MEAS_WAIT: begin
            if (meas_done) begin
              if (rng_up || rng_dn) begin
                state <= az_mode ? daz_pkg::DAZ_ST_ZERO_REQ : daz_pkg::DAZ_ST_MEAS_REQ;
              end else if (meas_left == 16'h0001) begin
                done_f <= 1'b1;
                state <= daz_pkg::DAZ_ST_IDLE;
              end else begin
                meas_left <= meas_left - 16'h0001;
                state <= daz_pkg::DAZ_ST_MEAS_REQ;
              end
            end
          end
          default: state <= daz_pkg::DAZ_ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Range table: hardware moves win over software writes
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int f = 0; f < NFUNC; f++) begin
        range_q[f] <= `DAZ_RST_RANGE;
      end
    end else if (ce_i) begin
      if (rng_up) begin
        range_q[act_func] <= act_range + 3'h1;
      end else if (rng_dn) begin
        range_q[act_func] <= act_range - 3'h1;
      end else if (lane0_wr && wb_adr_i == `DAZ_ADR_RANGE) begin
        range_q[func_sel] <= nearest_range(wb_dat_i);
      end
    end
  end

  // ****************************************
  // Offset and result stores
  // ****************************************
  // Calibration offsets have no reset: they are refilled from memory after every reset
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && state == daz_pkg::DAZ_ST_NVWAIT && nv_valid_i) begin
      cal_ofs[ld_idx] <= nv_data_i;
    end
  end

  // Volatile only: there is no path from here to the memory port
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      az_vld <= '0;
    end else if (ce_i && zero_done) begin
      az_ofs[cur_idx] <= conv_res_i.data;
      az_vld[cur_idx] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (ce_i && store_en && buf_cnt < (BW+1)'(BUF_DEPTH)) begin
      buf_mem[buf_cnt[BW-1:0]] <= store_val;
    end
  end

  // ****************************************
  // Converter request
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      conv_o <= '0;
    end else if (ce_i) begin
      conv_o.valid <= state == daz_pkg::DAZ_ST_SRCH_REQ || state == daz_pkg::DAZ_ST_ZERO_REQ
                      || state == daz_pkg::DAZ_ST_MEAS_REQ;
      conv_o.abort <= abort_now;
      conv_o.zero <= state == daz_pkg::DAZ_ST_ZERO_REQ;
      conv_o.func <= act_func;
      conv_o.range <= act_range;
      conv_o.aperture <= aper[act_func];
    end
  end

endmodule : daz_ctrl

// ---- verification/daz_ctrl_asserts.sv ----
// Port checks of the range/zero control
module daz_ctrl_asserts #(
  parameter int OW = 5
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire daz_pkg::daz_conv_req_t conv_o,
  input wire daz_pkg::daz_conv_res_t conv_res_i,
  input wire logic nv_req_o,
  input wire logic [OW-1:0] nv_addr_o,
  input wire logic nv_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  // ****************************************
  // Bus and link steps
  // ****************************************
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_pulse_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_once: assert property (s_take |=> s_pulse_ack)
    else $error("bus access not acked for exactly one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  chk_rd_unmapped: assert property (s_take ##0 (!wb_we_i && wb_adr_i == 8'h40) |=> !(|wb_dat_o))
    else $error("unmapped read not zero");
  chk_rd_cmd: assert property (s_take ##0 (!wb_we_i && wb_adr_i == 8'h04) |=> !(|wb_dat_o))
    else $error("command register read not zero");
  chk_nv_first: assert property ($fell(sys_rst_i) |=> nv_req_o && nv_addr_o == {OW{1'b0}})
    else $error("offset load did not start after reset");
  chk_nv_hold: assert property (nv_req_o |=> !nv_req_o until nv_valid_i)
    else $error("second offset request before answer");
  // One conversion outstanding; an abort drops it
  chk_conv_one: assert property (conv_o.valid |=>
    !conv_o.valid until (conv_res_i.done || conv_o.abort))
    else $error("conversion started while one outstanding");
  chk_done_gap: assert property (conv_res_i.done |=> !conv_o.valid)
    else $error("conversion restarted right after done");
  chk_abort_pulse: assert property (conv_o.abort |=> !conv_o.abort)
    else $error("abort wider than one cycle");
endmodule : daz_ctrl_asserts

bind daz_ctrl daz_ctrl_asserts #(.OW(OW)) daz_ctrl_asserts_inst (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .conv_o(conv_o), .conv_res_i(conv_res_i), .nv_req_o(nv_req_o), .nv_addr_o(nv_addr_o),
  .nv_valid_i(nv_valid_i));

// ---- verification/daz_fe_model.sv ----
// Converter and calibration memory stand-in for the range/zero control
module daz_fe_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic slow_i,
  input wire logic signed [31:0] sig_i,
  input wire daz_pkg::daz_conv_req_t conv_i,
  output daz_pkg::daz_conv_res_t res_o,
  input wire logic nv_req_i,
  input wire logic [4:0] nv_addr_i,
  output logic [31:0] nv_data_o,
  output logic nv_valid_o,
  output logic [7:0] zero_cnt_o,
  output logic [2:0] zero_rng_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Real front end drifts away from the stored calibration
  localparam logic signed [31:0] DRIFT = 32'sh00000007;
  int wait_cyc;
  logic zero_q;
  logic [2:0] rng_q;
  function automatic logic signed [31:0] level(input logic [2:0] r);
    logic signed [31:0] v;
    v = sig_i;
    for (int i = 0; i < 5; i++) if (i < r) v = v / 10;
    return v + DRIFT;
  endfunction : level
  // Idle data toggles so a stale read never looks right
  always_ff @(posedge clk_sys_i) begin
    res_o.done <= 1'b0;
    res_o.data <= ~res_o.data;
    if (sys_rst_i) begin
      res_o.data <= 32'h0;
      wait_cyc <= 0;
      zero_cnt_o <= 8'h00;
      zero_rng_o <= 3'h0;
    end else if (conv_i.abort) begin
      wait_cyc <= 0;
    end else if (conv_i.valid) begin
      wait_cyc <= slow_i ? 40 : 2;
      zero_q <= conv_i.zero;
      rng_q <= conv_i.range;
      if (conv_i.zero) begin
        zero_cnt_o <= zero_cnt_o + 8'h01;
        zero_rng_o <= conv_i.range;
      end
    end else if (wait_cyc == 1) begin
      res_o.done <= 1'b1;
      res_o.data <= zero_q ? DRIFT : level(rng_q);
      wait_cyc <= 0;
    end else if (wait_cyc > 1) begin
      wait_cyc <= wait_cyc - 1;
    end
  end
  // Stored calibration is index plus one, stale by design
  always_ff @(posedge clk_sys_i) begin
    nv_valid_o <= 1'b0;
    nv_data_o <= ~nv_data_o;
    if (sys_rst_i) begin
      nv_data_o <= 32'h0;
    end else if (nv_req_i) begin
      nv_valid_o <= 1'b1;
      nv_data_o <= 32'(nv_addr_i) + 32'h1;
    end
  end
endmodule : daz_fe_model

// ---- verification/testbench.sv ----
// Self-checking bench for the range/zero control
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
  logic ack, nv_req, nv_valid;
  logic [7:0] adr = 8'h00, zc, zc0;
  logic [31:0] wdat = 32'h0, rdat, rd_o, nv_data;
  logic signed [31:0] sig = 32'sh0;
  logic [4:0] nv_addr;
  logic [2:0] zr;
  daz_pkg::daz_conv_req_t conv;
  daz_pkg::daz_conv_res_t res;
  int fail_count = 0, checks_done = 0, cycles = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  daz_ctrl #(.DEF_APERTURE_CYC(32'h64)) daz_ctrl_inst (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
    .conv_o(conv), .conv_res_i(res), .nv_req_o(nv_req), .nv_addr_o(nv_addr),
    .nv_data_i(nv_data), .nv_valid_i(nv_valid));
  daz_fe_model daz_fe_model_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .slow_i(slow), .sig_i(sig), .conv_i(conv), .res_o(res), .nv_req_i(nv_req),
    .nv_addr_i(nv_addr), .nv_data_o(nv_data), .nv_valid_o(nv_valid), .zero_cnt_o(zc),
    .zero_rng_o(zr));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys_i);
  endtask : bus
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask : rd
  task automatic fd(input logic [3:0] i, input logic [31:0] e);
    bus(1'b1, 8'h1C, {28'h0, i});
    rd("result", 8'h20, e);
  endtask : fd
  // Host polls status instead of guessing the acquisition time
  task automatic idle();
    do bus(1'b0, 8'h18, 32'h0); while (rdat[0] !== 1'b0);
  endtask : idle
  task automatic results();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    do bus(1'b0, 8'h18, 32'h0); while (rdat[3] !== 1'b1);
    rd("ctrl", 8'h00, 32'h0);
    rd("armode", 8'h0C, 32'h1);
    rd("count", 8'h14, 32'h1);
    rd("unmapped", 8'h40, 32'h0);
    rd("cmd", 8'h04, 32'h0);
    $display("test defaults done");
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h08, 32'd2000);
    rd("range", 8'h08, 32'h0000FB02);
    sig <= 32'sd5000000;
    bus(1'b1, 8'h04, 32'h1);
    idle();
    `CHK("status", 3'h2, rdat[18:16])
    fd(4'h0, 32'd50004);
    $display("test fixed range done");
    bus(1'b1, 8'h0C, 32'h2);
    bus(1'b1, 8'h00, 32'h10);
    bus(1'b1, 8'h14, 32'h2);
    sig <= 32'sd1234567;
    bus(1'b1, 8'h04, 32'h1);
    @(posedge clk_sys_i iff (conv.valid && conv.zero));
    sig <= -32'sd5000000;
    idle();
    `CHK("zero range", 3'h1, zr)
    `CHK("range", 3'h1, rdat[18:16])
    fd(4'h0, 32'h80000001);
    fd(4'h1, 32'h80000001);
    $display("test single search done");
    bus(1'b1, 8'h00, 32'h11);
    rd("armode f1", 8'h0C, 32'h1);
    sig <= 32'sd123456;
    zc0 = zc;
    bus(1'b1, 8'h04, 32'h1);
    @(posedge clk_sys_i iff (conv.valid && conv.zero));
    `CHK("conv func", 3'h1, conv.func)
    `CHK("conv range", 3'h0, conv.range)
    `CHK("conv aperture", 32'h64, conv.aperture)
    sig <= 32'sd5000000;
    idle();
    `CHK("range", 3'h2, rdat[18:16])
    `CHK("zero count", 8'h03, 8'(zc - zc0))
    fd(4'h0, 32'd50000);
    $display("test tracking done");
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h08, 32'd2000);
    slow <= 1'b1;
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h04, 32'h8);
    idle();
    `CHK("aborted", 1'b1, rdat[2])
    `CHK("zero range", 3'h2, zr)
    slow <= 1'b0;
    bus(1'b1, 8'h04, 32'h1);
    idle();
    fd(4'h0, 32'd50000);
    $display("test zero once done");
    bus(1'b1, 8'h04, 32'h2);
    rd("armode", 8'h0C, 32'h1);
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h10, 32'h5);
    bus(1'b1, 8'h04, 32'h4);
    idle();
    `CHK("done", 1'b1, rdat[1])
    rd("aperture", 8'h10, 32'h64);
    rd("armode", 8'h0C, 32'h1);
    fd(4'h0, 32'd50000);
    $display("test default config done");
    results();
  end
endmodule : testbench
